// file: logic/stuck_group_timer.sv
// One stuck timer for a group of three inspection inputs.
// Assumes synchronised inputs and a one-cycle millisecond tick.
`include "stuck_monitor_consts.svh"
`default_nettype none
module stuck_group_timer #(
   parameter int CNT_W = `MS_CNT_W,
   parameter logic [`MS_CNT_W-1:0] AUTO_MS = `MS_CNT_W'(`AUTO_LIMIT_MS),
   parameter logic [`MS_CNT_W-1:0] INSP_MS = `MS_CNT_W'(`INSP_LIMIT_MS)
) (
   input wire logic clk, // System clock.
   input wire logic nrst, // Synchronous reset, active low.
   input wire logic ms_tick, // One pulse each millisecond.
   input wire logic monitor_en, // Monitoring option enabled.
   input wire stuck_monitor_pkg::op_mode_t mode, // Current mode.
   input wire logic en_in, // Enable button.
   input wire logic up_in, // Up button.
   input wire logic dn_in, // Down button.
   output logic stuck // One-cycle pulse when limit passes.
);
   logic [CNT_W-1:0] cnt_r;
   logic cond;
   logic mode_prev_r;
   logic fired_r;
   logic [CNT_W-1:0] limit;

   // Stuck condition for the current mode.
   always_comb
   begin
      if (mode == stuck_monitor_pkg::MODE_AUTO)
      begin
         cond = en_in | up_in | dn_in;
         limit = AUTO_MS;
      end
      else
      begin
         cond = (en_in | up_in | dn_in) &&
            !({en_in, up_in, dn_in} == 3'b110) &&
            !({en_in, up_in, dn_in} == 3'b101);
         limit = INSP_MS;
      end
   end

   // Counter restarts when the condition ends or the mode changes.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cnt_r <= '0;
         fired_r <= 1'b0;
         mode_prev_r <= 1'b0;
      end
      else
      begin
         mode_prev_r <= mode;
         if (!monitor_en || !cond || (mode_prev_r != mode))
         begin
            cnt_r <= '0;
            fired_r <= 1'b0;
         end
         else if (ms_tick && !fired_r)
         begin
            if (cnt_r >= limit)
               fired_r <= 1'b1;
            else
               cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   assign stuck = monitor_en && cond && ms_tick && !fired_r &&
      (cnt_r >= limit) && (mode_prev_r == mode);
endmodule : stuck_group_timer
`default_nettype wire

// file: logic/stuck_inspection_input_monitor.sv
// Stuck inspection input monitor: top level with Avalon-MM registers.
// Assumes asynchronous pushbutton pins and a floor-arrival level input.
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`include "stuck_monitor_consts.svh"
`default_nettype none
module stuck_inspection_input_monitor #(
   parameter int MS_DIV = `MS_CYCLES
) (
   input wire logic clk, // System clock, 200 MHz.
   input wire logic nrst, // Synchronous reset, active low.
   input wire logic [3:0] avs_address, // Byte address.
   input wire logic avs_read, // Read strobe.
   input wire logic avs_write, // Write strobe.
   input wire logic [31:0] avs_writedata, // Write data.
   input wire logic [3:0] avs_byteenable, // Byte enables.
   output logic [31:0] avs_readdata, // Read data.
   output logic avs_waitrequest, // Stall.
   input wire logic cartop_enable_in, // Cartop enable pin.
   input wire logic cartop_up_in, // Cartop up pin.
   input wire logic cartop_down_in, // Cartop down pin.
   input wire logic panel_enable_in, // Car panel enable pin.
   input wire logic panel_up_in, // Car panel up pin.
   input wire logic panel_down_in, // Car panel down pin.
   input wire logic inspection_mode_in, // Car on inspection pin.
   input wire logic at_floor_in, // Car stopped at floor pin.
   input wire logic fault_reset_in, // Fault reset pin.
   output logic cartop_stuck_event, // Cartop stuck pulse.
   output logic panel_stuck_event, // Panel stuck pulse.
   output logic stuck_shutdown_fault, // Latched shutdown fault.
   output logic hall_call_release, // Reassign or cancel hall calls.
   output logic door_cycle_req, // Cycle doors once at floor.
   output logic car_call_cancel, // Cancel all car calls.
   output logic out_of_service, // Car held out of service.
   output logic irq // Level interrupt.
);
   // Pin synchronisers: two flops per pin.
   localparam int NPIN = 9;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1_r;
   logic [NPIN-1:0] sync2_r;
   assign pin_raw = {fault_reset_in, at_floor_in, inspection_mode_in,
      panel_down_in, panel_up_in, panel_enable_in,
      cartop_down_in, cartop_up_in, cartop_enable_in};

   // Second flop alone reads the first, keeping metastability contained.
   // The floor and fault reset pins pass the same two stages, so their
   // two-cycle lag matches that of the buttons.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= pin_raw;
         sync2_r <= sync1_r;
      end
   end

   logic at_floor;
   logic fault_reset_pin;
   logic fault_reset_pin_prev_r;
   stuck_monitor_pkg::op_mode_t mode;
   assign at_floor = sync2_r[7];
   assign fault_reset_pin = sync2_r[8];

   // Registers.
   logic ctrl_enable_r;
   logic ctrl_insp_r;
   logic [`ST_W-1:0] status_r;
   logic [`ST_W-1:0] mask_r;
   logic sw_reset_pulse;
   logic wr_ctrl;
   logic wr_status;
   logic wr_mask;

   // Inspection is entered by the pin or forced from software.
   // The two are ORed: software can force inspection but can never take
   // a car that is on inspection by its switch back to automatic.
   assign mode = (sync2_r[6] || ctrl_insp_r) ?
      stuck_monitor_pkg::MODE_INSP : stuck_monitor_pkg::MODE_AUTO;

   // Millisecond timebase, shared by both timers. The first tick after a
   // press may fall anywhere within a millisecond, so each limit is met to
   // within one tick; a divider per group would cost area for no gain.
   logic [31:0] div_r;
   logic ms_tick;
   assign ms_tick = (div_r == 32'(MS_DIV - 1));
   always_ff @(posedge clk)
   begin
      if (!nrst)
         div_r <= 32'h0000_0000;
      else if (ms_tick)
         div_r <= 32'h0000_0000;
      else
         div_r <= div_r + 32'h0000_0001;
   end

   // One timer per input group.
   logic cartop_hit;
   logic panel_hit;
   stuck_group_timer cartop_timer (
      .clk(clk),
      .nrst(nrst),
      .ms_tick(ms_tick),
      .monitor_en(ctrl_enable_r),
      .mode(mode),
      .en_in(sync2_r[0]),
      .up_in(sync2_r[1]),
      .dn_in(sync2_r[2]),
      .stuck(cartop_hit)
   );
   stuck_group_timer panel_timer (
      .clk(clk),
      .nrst(nrst),
      .ms_tick(ms_tick),
      .monitor_en(ctrl_enable_r),
      .mode(mode),
      .en_in(sync2_r[3]),
      .up_in(sync2_r[4]),
      .dn_in(sync2_r[5]),
      .stuck(panel_hit)
   );

   // Event outputs are registered pulses.
   // Status and the shutdown sequencer take the unregistered hits; the
   // events feed no logic here and never gate motion or doors by themselves.
   // events informational only
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cartop_stuck_event <= 1'b0;
         panel_stuck_event <= 1'b0;
      end
      else
      begin
         cartop_stuck_event <= cartop_hit;
         panel_stuck_event <= panel_hit;
      end
   end

   // Fault reset from the pin edge or from software.
   // The pin acts on its rising edge, so a button held down cannot mask
   // a fault that is raised while it is still pressed. The edge detector
   // starts at the pin's idle level, so no false edge follows reset.
   logic fault_reset;
   always_ff @(posedge clk)
   begin
      if (!nrst)
         fault_reset_pin_prev_r <= 1'b0;
      else
         fault_reset_pin_prev_r <= fault_reset_pin;
   end
   assign fault_reset = (fault_reset_pin && !fault_reset_pin_prev_r) ||
      sw_reset_pulse;

   // Shutdown sequencing.
   // A stuck input found on automatic first parks the fault in pending:
   // the car finishes its run and the fault takes hold at the next floor.
   // A fault reset while pending cancels it before the car is shut down.
   stuck_monitor_pkg::shutdown_t sd_r;
   logic auto_stuck;
   logic door_done_r;
   assign auto_stuck = (cartop_hit || panel_hit) &&
      (mode == stuck_monitor_pkg::MODE_AUTO);

   always_ff @(posedge clk)
   begin
      if (!nrst)
         sd_r <= stuck_monitor_pkg::SD_IDLE;
      else
      begin
         unique case (sd_r)
            stuck_monitor_pkg::SD_IDLE:
               if (auto_stuck)
                  sd_r <= stuck_monitor_pkg::SD_PENDING;
            stuck_monitor_pkg::SD_PENDING:
               if (fault_reset)
                  sd_r <= stuck_monitor_pkg::SD_IDLE;
               else if (at_floor)
                  sd_r <= stuck_monitor_pkg::SD_SHUTDOWN;
            stuck_monitor_pkg::SD_SHUTDOWN:
               if (fault_reset)
                  sd_r <= stuck_monitor_pkg::SD_IDLE;
            default:
               sd_r <= stuck_monitor_pkg::SD_IDLE;
         endcase
      end
   end

   // Door cycle is requested once per shutdown, on the first cycle at floor.
   always_ff @(posedge clk)
   begin
      if (!nrst)
         door_done_r <= 1'b0;
      else if (sd_r != stuck_monitor_pkg::SD_SHUTDOWN)
         door_done_r <= 1'b0;
      else
         door_done_r <= 1'b1;
   end

   // Shutdown outputs, all registered.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         stuck_shutdown_fault <= 1'b0;
         hall_call_release <= 1'b0;
         door_cycle_req <= 1'b0;
         car_call_cancel <= 1'b0;
         out_of_service <= 1'b0;
      end
      else
      begin
         stuck_shutdown_fault <= (sd_r == stuck_monitor_pkg::SD_SHUTDOWN);
         hall_call_release <= (sd_r != stuck_monitor_pkg::SD_IDLE);
         door_cycle_req <= (sd_r == stuck_monitor_pkg::SD_SHUTDOWN) &&
            !door_done_r;
         car_call_cancel <= (sd_r == stuck_monitor_pkg::SD_SHUTDOWN);
         out_of_service <= (sd_r == stuck_monitor_pkg::SD_SHUTDOWN);
      end
   end

   // Read handshake: one wait state lets read data come from a flop and
   // still stand at the edge where waitrequest is sampled low. Writes need
   // no wait state and land at the edge that takes them.
   logic rd_ack_r;
   logic rd_take;
   assign rd_take = avs_read && !rd_ack_r;
   assign avs_waitrequest = rd_take;
   always_ff @(posedge clk)
   begin
      if (!nrst)
         rd_ack_r <= 1'b0;
      else
         rd_ack_r <= rd_take;
   end

   // Write decode; only byte lane 0 carries register bits.
   assign wr_ctrl = avs_write && avs_byteenable[0] &&
      (avs_address == `REG_CTRL);
   assign wr_status = avs_write && avs_byteenable[0] &&
      (avs_address == `REG_STATUS);
   assign wr_mask = avs_write && avs_byteenable[0] &&
      (avs_address == `REG_MASK);
   assign sw_reset_pulse = wr_ctrl && avs_writedata[`CTRL_RESET_BIT];

   // Control register; the reset bit is self clearing and never stored.
   // Dropping the enable bit restarts both timers at once, so a stuck
   // button is timed afresh when monitoring is turned back on.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ctrl_enable_r <= 1'b0;
         ctrl_insp_r <= 1'b0;
         mask_r <= '0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_enable_r <= avs_writedata[`CTRL_ENABLE_BIT];
            ctrl_insp_r <= avs_writedata[`CTRL_INSP_BIT];
         end
         if (wr_mask)
            mask_r <= avs_writedata[`ST_W-1:0];
      end
   end

   // Status set terms. The fault bit is set on the first cycle of
   // shutdown only, before the fault flop catches up, so clearing it
   // during a long shutdown does not see it come straight back.
   logic [`ST_W-1:0] status_set;
   always_comb
   begin
      status_set = '0;
      status_set[`ST_CARTOP_BIT] = cartop_hit;
      status_set[`ST_PANEL_BIT] = panel_hit;
      status_set[`ST_FAULT_BIT] = !stuck_shutdown_fault &&
         (sd_r == stuck_monitor_pkg::SD_SHUTDOWN);
   end

   // Sticky status: a new event wins over a write-one clear.
   always_ff @(posedge clk)
   begin
      if (!nrst)
         status_r <= '0;
      else if (wr_status)
         status_r <= (status_r & ~avs_writedata[`ST_W-1:0]) | status_set;
      else
         status_r <= status_r | status_set;
   end

   // Level interrupt: it stays high until software clears the cause or
   // masks it, so an event cannot be lost between two polls.
   assign irq = |(status_r & mask_r);

   // Read data registered; unmapped offsets read as zero.
   // Loaded in the wait state only, so the word stands until the next read.
   always_ff @(posedge clk)
   begin
      if (!nrst)
         avs_readdata <= 32'h0000_0000;
      else if (rd_take)
      begin
         unique case (avs_address)
            `REG_CTRL:
               avs_readdata <= {30'h0, ctrl_insp_r, ctrl_enable_r};
            `REG_STATUS:
               avs_readdata <= {29'h0, status_r};
            `REG_MASK:
               avs_readdata <= {29'h0, mask_r};
            `REG_STATE:
               avs_readdata <= {26'h0, sync2_r[5:0]} |
                  {28'h0, out_of_service, 3'h0};
            default:
               avs_readdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule : stuck_inspection_input_monitor
`default_nettype wire

// file: logic/stuck_monitor_consts.svh
// Constants for the stuck inspection input monitor.
// Assumes a 200 MHz clock and a 1 ms internal timebase.
`ifndef STUCK_MONITOR_CONSTS_SVH
`define STUCK_MONITOR_CONSTS_SVH
// Clock rate in kHz and the derived cycles per millisecond.
`define CLK_KHZ 200000
`define MS_CYCLES (`CLK_KHZ)
// Automatic mode limit in milliseconds.
`define AUTO_LIMIT_MS 250
// Inspection mode limit in milliseconds (five seconds).
`define INSP_LIMIT_MS 5000
// Width of the millisecond stuck counters.
`define MS_CNT_W 13
// Register byte offsets on the Avalon-MM port.
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_MASK 4'h8
`define REG_STATE 4'hC
// Control register fields.
`define CTRL_ENABLE_BIT 0
`define CTRL_INSP_BIT 1
`define CTRL_RESET_BIT 2
// Status and mask register fields.
`define ST_CARTOP_BIT 0
`define ST_PANEL_BIT 1
`define ST_FAULT_BIT 2
`define ST_W 3
`endif

// file: logic/stuck_monitor_pkg.sv
// Types for the stuck inspection input monitor.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package stuck_monitor_pkg;
   // Operating mode seen by the stuck timers.
   typedef enum logic {
      MODE_AUTO,
      MODE_INSP
   } op_mode_t;
   // Shutdown sequencing states.
   typedef enum logic [1:0] {
      SD_IDLE,
      SD_PENDING,
      SD_SHUTDOWN
   } shutdown_t;
endpackage : stuck_monitor_pkg
`default_nettype wire

// file: test/button_panel_model.sv
// Pushbutton model: the six inspection pins seen by the monitor.
// Assumes the bench changes its commands just after a rising edge.
`default_nettype none
module button_panel_model (
   input wire logic clk, // System clock.
   input wire logic [2:0] ct_cmd, // Cartop {down, up, enable} wanted.
   input wire logic [2:0] cp_cmd, // Panel {down, up, enable} wanted.
   output logic [2:0] ct_pin = 3'h0, // Cartop contacts.
   output logic [2:0] cp_pin = 3'h0 // Panel contacts.
);
   // Contacts close one cycle after the command, as a hand lags intent.
   always @(posedge clk)
   begin
      ct_pin <= ct_cmd;
      cp_pin <= cp_cmd;
   end
endmodule : button_panel_model
`default_nettype wire

// file: test/stuck_monitor_chk.sv
// Checker: properties on the monitor's top-level ports.
// Assumes one clock domain and a bind from the bench top.
`default_nettype none
module stuck_monitor_chk (
   input wire logic clk, // System clock.
   input wire logic nrst, // Reset, active low.
   input wire logic at_floor_in, // Floor pin.
   input wire logic fault_reset_in, // Fault reset pin.
   input wire logic avs_write, // Register write strobe.
   input wire logic cartop_stuck_event, // Cartop pulse.
   input wire logic panel_stuck_event, // Panel pulse.
   input wire logic stuck_shutdown_fault, // Fault level.
   input wire logic hall_call_release, // Hall call release.
   input wire logic door_cycle_req, // Door pulse.
   input wire logic car_call_cancel, // Car call cancel.
   input wire logic out_of_service // Out of service.
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // An event is a pulse exactly one cycle wide.
   sequence one_pulse(s);
      s ##1 !s;
   endsequence
   ct_pulse_a: assert property (
      cartop_stuck_event |-> one_pulse(cartop_stuck_event))
      else $error("Cartop event wider than one cycle.");
   cp_pulse_a: assert property (
      panel_stuck_event |-> one_pulse(panel_stuck_event))
      else $error("Panel event wider than one cycle.");
   latch_hold_a: assert property (
      stuck_shutdown_fault && !fault_reset_in && !$past(fault_reset_in)
      && !$past(fault_reset_in, 2) && !$past(fault_reset_in, 3)
      && !$past(fault_reset_in, 4) && !avs_write
      |=> stuck_shutdown_fault)
      else $error("Fault dropped without a fault reset.");
   floor_wait_a: assert property (
      $rose(stuck_shutdown_fault) |-> $past(at_floor_in, 4))
      else $error("Fault raised away from a floor.");
   hall_cause_a: assert property (
      $rose(hall_call_release) |-> cartop_stuck_event ||
      panel_stuck_event || $past(cartop_stuck_event || panel_stuck_event))
      else $error("Hall release without a stuck event.");
   fault_outs_a: assert property (
      stuck_shutdown_fault |->
      out_of_service && car_call_cancel && hall_call_release)
      else $error("Fault without its shutdown outputs.");
   door_once_a: assert property (
      door_cycle_req |=> !door_cycle_req && stuck_shutdown_fault)
      else $error("Door cycle request outside shutdown entry.");
   oos_cause_a: assert property (
      out_of_service |-> stuck_shutdown_fault)
      else $error("Out of service without the fault.");
endmodule : stuck_monitor_chk
`default_nettype wire

// file: test/test_stuck_inspection_input_monitor.sv
// Bench top: drives registers and pins, checks events and the fault.
// Assumes the model and the checker are compiled before this file.
`default_nettype none
module test_stuck_inspection_input_monitor;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 10; // Short millisecond keeps the run brief.
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic [3:0] adr = 4'h0;
   logic rd_en = 1'h0;
   logic wr_en = 1'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat, rd;
   logic wait_req, ct_ev, cp_ev, fault, hall, door, cancel, oos, irq;
   logic [2:0] ct_cmd = 3'h0;
   logic [2:0] cp_cmd = 3'h0;
   logic [2:0] ct_pin, cp_pin;
   logic insp = 1'h0;
   logic floor = 1'h0;
   logic frst = 1'h0;
   int failures = 0;
   int compares = 0;
   int ct_n = 0;
   int cp_n = 0;
   int door_n = 0;
   int n, e0;
   always #2.5 clk = ~clk;
   // Pulse tallies count every event, so a missing or a double event shows.
   always @(posedge clk)
   begin
      ct_n <= ct_n + ((ct_ev === 1'h1) ? 1 : 0);
      cp_n <= cp_n + ((cp_ev === 1'h1) ? 1 : 0);
      door_n <= door_n + ((door === 1'h1) ? 1 : 0);
   end
   button_panel_model button_panel_model_inst (.clk(clk),
      .ct_cmd(ct_cmd), .cp_cmd(cp_cmd), .ct_pin(ct_pin), .cp_pin(cp_pin));
   stuck_inspection_input_monitor #(.MS_DIV(DIV))
   stuck_inspection_input_monitor_inst (.clk(clk), .nrst(nrst),
      .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
      .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat),
      .avs_waitrequest(wait_req), .cartop_enable_in(ct_pin[0]),
      .cartop_up_in(ct_pin[1]), .cartop_down_in(ct_pin[2]),
      .panel_enable_in(cp_pin[0]), .panel_up_in(cp_pin[1]),
      .panel_down_in(cp_pin[2]), .inspection_mode_in(insp),
      .at_floor_in(floor), .fault_reset_in(frst),
      .cartop_stuck_event(ct_ev), .panel_stuck_event(cp_ev),
      .stuck_shutdown_fault(fault), .hall_call_release(hall),
      .door_cycle_req(door), .car_call_cancel(cancel),
      .out_of_service(oos), .irq(irq));
   task automatic close_out();
      $display("Compares %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One bus transfer: the request stands until waitrequest is seen low
   // before an edge; read data are taken for that same edge.
   task automatic bus(input logic wr, input logic [3:0] a,
         input logic [31:0] wd);
      int k;
      logic done;
      k = 0;
      done = 1'h0;
      adr <= a;
      wdat <= wd;
      wr_en <= wr;
      rd_en <= !wr;
      while (!done)
      begin
         @(negedge clk);
         done = (wait_req === 1'h0);
         rd = rdat;
         @(posedge clk);
         k++;
         if (k > 100)
         begin
            failures++;
            close_out();
         end
      end
      wr_en <= 1'h0;
      rd_en <= 1'h0;
      @(posedge clk);
   endtask : bus
   task automatic press(input int i, input logic v);
      ct_cmd <= (i < 3 && v) ? 3'(1 << i) : 3'h0;
      cp_cmd <= (i > 2 && v) ? 3'(1 << (i - 3)) : 3'h0;
   endtask : press
   // Bounded wait for a group's event; c returns the cycles taken.
   task automatic wait_ev(input logic grp, output int c);
      logic hit;
      c = 0;
      hit = 1'h0;
      while (!hit)
      begin
         @(negedge clk);
         hit = ((grp ? cp_ev : ct_ev) === 1'h1);
         @(posedge clk);
         c++;
         if (c > 60000)
         begin
            failures++;
            close_out();
         end
      end
   endtask : wait_ev
   // Event must come after the limit, allowing tick alignment and sync.
   function automatic logic in_win(input int c, input int ms);
      return c >= ms * DIV && c <= (ms + 2) * DIV + 8;
   endfunction : in_win
   initial
   begin
      n = $urandom(66669);
      repeat (12) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      // Registers clear at reset; a write to a hole is ignored.
      bus(1'h1, 4'h2, 32'hFFFF_FFFF);
      for (int a = 0; a < 16; a++)
      begin
         bus(1'h0, 4'(a), 32'h0000_0000);
         check("reset reg", rd, 32'h0000_0000);
      end
      press(1, 1'h1);
      repeat (3000) @(posedge clk);
      check("disabled ev", 32'(ct_n), 32'h0000_0000);
      press(1, 1'h0);
      bus(1'h1, 4'h0, 32'h0000_0001);
      bus(1'h1, 4'h8, 32'h0000_0007);
      for (int i = 0; i < 6; i++)
      begin
         e0 = ct_n + cp_n;
         press(i, 1'h1);
         repeat ($urandom_range(2400, 50)) @(posedge clk);
         press(i, 1'h0);
         repeat (5) @(posedge clk);
         press(i, 1'h1);
         wait_ev(i > 2, n);
         press(i, 1'h0);
         repeat (4) @(posedge clk);
         check("auto delay", 32'(in_win(n, 250)), 32'h1);
         check("one event", 32'(ct_n + cp_n), 32'(e0 + 1));
         check("hall", 32'(hall), 32'h1);
         check("held fault", 32'(fault), 32'h0);
         bus(1'h0, 4'h4, 32'h0000_0000);
         check("status", rd, (i > 2) ? 32'h2 : 32'h1);
         check("irq", 32'(irq), 32'h1);
         if (i == 0)
         begin
            bus(1'h1, 4'h8, 32'h0000_0000);
            check("irq masked", 32'(irq), 32'h0);
            bus(1'h1, 4'h8, 32'h0000_0007);
         end
         bus(1'h1, 4'h4, 32'h0000_0007);
         check("irq clear", 32'(irq), 32'h0);
      end
      floor <= 1'h1;
      repeat (10) @(posedge clk);
      check("fault", 32'({fault, oos, cancel}), 32'h7);
      check("door", 32'(door_n), 32'h1);
      bus(1'h0, 4'h4, 32'h0000_0000);
      check("fault bit", rd, 32'h4);
      floor <= 1'h0;
      repeat (200) @(posedge clk);
      check("latched", 32'({fault, oos}), 32'h3);
      frst <= 1'h1;
      repeat (4) @(posedge clk);
      frst <= 1'h0;
      repeat (10) @(posedge clk);
      check("cleared", 32'({fault, oos, hall}), 32'h0);
      bus(1'h1, 4'h4, 32'h0000_0007);
      // Inspection: enable plus down is legal, up plus down is stuck.
      insp <= 1'h1;
      floor <= 1'h1;
      e0 = ct_n;
      ct_cmd <= 3'h5;
      cp_cmd <= 3'h6;
      wait_ev(1'h1, n);
      repeat (500) @(posedge clk);
      check("insp delay", 32'(in_win(n, 5000)), 32'h1);
      check("exempt", 32'(ct_n), 32'(e0));
      check("no fault", 32'({fault, hall}), 32'h0);
      close_out();
   end
endmodule : test_stuck_inspection_input_monitor
bind stuck_inspection_input_monitor stuck_monitor_chk stuck_monitor_chk_inst (
   .clk, .nrst, .at_floor_in, .fault_reset_in, .avs_write, .cartop_stuck_event,
   .panel_stuck_event, .stuck_shutdown_fault, .hall_call_release,
   .door_cycle_req, .car_call_cancel, .out_of_service);
`default_nettype wire
